/* hwwdt_pkg.sv */
// Package for the hardware watchdog timer: SFR addresses, field layouts,
// reset values, timing constants and the state carriers.
// Assumes a single 40 MHz peripheral clock domain.
package hwwdt_pkg;
	localparam logic [7:0] SERVICE_ADDR      = 8'ha6;   // watchdog_service, write only
	localparam logic [7:0] TIMEOUT_SEL_ADDR  = 8'ha7;   // watchdog_timeout_select
	localparam logic [7:0] UNLOCK_FIRST      = 8'h1e;
	localparam logic [7:0] UNLOCK_SECOND     = 8'he1;
	localparam int         SEL_LSB           = 0;
	localparam int         SEL_W             = 3;
	localparam logic [2:0] SEL_RESET         = 3'h0;
	localparam int         BASE_W            = 14;
	localparam logic [13:0] BASE_MAX         = 14'h3fff;
	localparam int         PRESC_W           = 7;
	localparam logic [6:0] PRESC_RESET       = 7'h00;
	localparam logic [13:0] BASE_RESET       = 14'h0000;
	// Reset pulse length in peripheral clock periods
	localparam int         RST_PULSE_PERIODS = 96;
	localparam logic [6:0] RST_PULSE_CYCLES  = 7'(RST_PULSE_PERIODS);
	localparam logic [6:0] PULSE_RESET       = 7'h00;
	// Peripheral clock cycles per machine cycle
	localparam int         MC_CLOCKS         = 6;
	localparam logic [2:0] MC_LAST           = 3'(MC_CLOCKS - 1);
	localparam logic [2:0] MC_RESET          = 3'h0;
	localparam logic [7:0] RESERVED_READ     = 8'h00;

	typedef enum logic [1:0] {
		HWWDT_OFF   = 2'b00,
		HWWDT_RUN   = 2'b01,
		HWWDT_PULSE = 2'b11
	} hwwdt_state_t;

	// SFR write/read bus from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hwwdt_sfr_t;

	typedef struct packed {
		hwwdt_state_t state;
		logic         armed;     // 1EH seen, waiting for E1H
		logic [2:0]   sel;
		logic [2:0]   mc;        // machine cycle divider
		logic [6:0]   presc;
		logic [13:0]  base;
		logic [6:0]   pulse;
		logic [7:0]   rdata;
		logic         rst_n_q;
		logic         hold;      // waiting for wake interrupt to rise
	} hwwdt_regs_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} hwwdt_sync_t;
endpackage

/* hwwdt_sync.sv */
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the level stays stable for several clocks.
`timescale 1ns/10ps
`default_nettype none
module hwwdt_sync (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic ce_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic [1:0] sr;
	logic [1:0] next_sr;

	// Only the second stage is ever seen outside
	always_comb begin
		next_sr = {sr[0], d_in};
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sr <= 2'h3;
		end else if (ce_in) begin
			sr <= next_sr;
		end
	end

	assign q_out = sr[1];
endmodule
`default_nettype wire

/* hwwdt_top.sv */
// Hardware watchdog timer: SFR decode, unlock sequence, prescaled 14-bit
// counter and the timed low reset pulse. Assumes the core drives the SFR
// bus on clk_in and that ce_in falls low while the oscillator is stopped.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Writing 1EH then E1H to the service register enables the watchdog.
// R2: After any reset the watchdog is disabled and does not count.
// R3: While enabled the counter advances once per machine cycle.
// R4: Once enabled only reset or own overflow disables it.
// R5: 14-bit base counter overflowing at 3FFFH triggers a device reset.
// R6: Repeating the 1EH, E1H pair clears the counter.
// R7: Service register is write only; the count is never readable.
// R8: Overflow drives a low reset pulse for 96 peripheral clocks.
// R9: A prescaler of up to 2^7 stages extends the time-out.
// R10: Select field picks 16384 times 2^field machine cycles.
// R11: Time-out register at A7H, field resets to 000, upper bits reserved.
// R12: Software never sets the reserved upper time-out bits.
// R13: In power-down the count holds without advancing.
// R14: After level interrupt wake-up, counting waits until the input is high.
// R15: Software should service before power-down and after wake-up.
// R16: Software should wake periodically from idle to service the watchdog.
// R17: Any value other than E1H after 1EH discards the sequence; the code keeps it armed on a repeated 1EH.
// R18: Power-down stops the oscillator; idle keeps peripherals clocked.
module hwwdt_top (
	input  wire logic                clk_in,
	input  wire logic                srst_in,
	input  wire logic                ce_in,
	input  wire hwwdt_pkg::hwwdt_sfr_t sfr_in,
	input  wire logic                pd_wake_in,
	input  wire logic                wake_int_n_in,
	output logic [7:0]               rdata_out,
	output logic                     rst_n_out,
	output logic                     enabled_out
);
	hwwdt_pkg::hwwdt_regs_t r;
	hwwdt_pkg::hwwdt_regs_t next_r;
	logic                   int_n_sync;
	logic                   wr_service;
	logic                   wr_sel;
	logic                   unlock_done;
	logic                   mc_tick;
	logic                   presc_done;
	logic                   base_ovf;
	logic [6:0]             presc_limit;

	// Wake interrupt pin comes from outside the clock domain
	hwwdt_sync u_int_sync (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.ce_in   (ce_in),
		.d_in    (wake_int_n_in),
		.q_out   (int_n_sync)
	);

	// SFR address decode
	always_comb begin
		wr_service = 1'b0;
		wr_sel     = 1'b0;
		if (sfr_in.wr && sfr_in.addr == hwwdt_pkg::SERVICE_ADDR) begin
			wr_service = 1'b1;
		end else if (sfr_in.wr && sfr_in.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR) begin
			wr_sel = 1'b1;
		end
	end

	// Second byte must be the next service register write; writes to other addresses do not break it
	assign unlock_done = wr_service && r.armed && sfr_in.wdata == hwwdt_pkg::UNLOCK_SECOND; // R1 R6 R17
	// Prescaler wraps after 2^sel machine cycles
	assign presc_limit = 7'((8'h01 << r.sel) - 8'h01); // R9 R10
	assign mc_tick     = (r.mc == hwwdt_pkg::MC_LAST) && !r.hold; // R3 R14
	assign presc_done  = mc_tick && (r.presc == presc_limit);
	assign base_ovf    = presc_done && (r.base == hwwdt_pkg::BASE_MAX); // R5

	// Next-state logic for the whole block
	always_comb begin
		next_r = r;
		next_r.rdata = r.rdata;
		// Unlock tracking
		if (wr_service) begin
			next_r.armed = (sfr_in.wdata == hwwdt_pkg::UNLOCK_FIRST); // R17
		end
		// Only the low select bits are stored; reserved bits read zero
		if (wr_sel) begin
			next_r.sel = sfr_in.wdata[hwwdt_pkg::SEL_LSB +: hwwdt_pkg::SEL_W]; // R11 R12
		end
		// Read mux: service register and counter never return data
		if (sfr_in.rd && sfr_in.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR) begin
			next_r.rdata = {5'h00, r.sel}; // R11
		end else if (sfr_in.rd) begin
			next_r.rdata = hwwdt_pkg::RESERVED_READ; // R7
		end
		// Wake from level interrupt holds counting until the pin is high
		if (pd_wake_in && !int_n_sync) begin
			next_r.hold = 1'b1; // R14
		end else if (int_n_sync) begin
			next_r.hold = 1'b0;
		end
		case (r.state)
			hwwdt_pkg::HWWDT_OFF: begin
				next_r.rst_n_q = 1'b1;
				if (unlock_done) begin
					next_r.state = hwwdt_pkg::HWWDT_RUN; // R1
					next_r.mc    = hwwdt_pkg::MC_RESET;
					next_r.presc = hwwdt_pkg::PRESC_RESET;
					next_r.base  = hwwdt_pkg::BASE_RESET;
				end
			end
			hwwdt_pkg::HWWDT_RUN: begin
				// No write path leads back to OFF
				if (unlock_done) begin
					next_r.mc    = hwwdt_pkg::MC_RESET; // R6
					next_r.presc = hwwdt_pkg::PRESC_RESET;
					next_r.base  = hwwdt_pkg::BASE_RESET;
				end else if (base_ovf) begin
					next_r.state   = hwwdt_pkg::HWWDT_PULSE; // R5 R8
					next_r.pulse   = hwwdt_pkg::PULSE_RESET;
					next_r.rst_n_q = 1'b0;
				end else if (!r.hold) begin
					next_r.mc = (r.mc == hwwdt_pkg::MC_LAST) ? hwwdt_pkg::MC_RESET : r.mc + 3'h1; // R3
					if (mc_tick) begin
						next_r.presc = presc_done ? hwwdt_pkg::PRESC_RESET : r.presc + 7'h01; // R9
						if (presc_done) begin
							next_r.base = r.base + 14'h0001; // R5
						end
					end
				end
			end
			hwwdt_pkg::HWWDT_PULSE: begin
				// Pulse counts peripheral clocks; then the watchdog is off again
				if (r.pulse == hwwdt_pkg::RST_PULSE_CYCLES - 7'h01) begin
					next_r.state   = hwwdt_pkg::HWWDT_OFF; // R4 R8
					next_r.rst_n_q = 1'b1;
					next_r.armed   = 1'b0;
					next_r.sel     = hwwdt_pkg::SEL_RESET;
					next_r.base    = hwwdt_pkg::BASE_RESET;
					next_r.presc   = hwwdt_pkg::PRESC_RESET;
					next_r.mc      = hwwdt_pkg::MC_RESET;
				end else begin
					next_r.pulse   = r.pulse + 7'h01;
					next_r.rst_n_q = 1'b0;
				end
			end
			default: begin
				next_r.state = hwwdt_pkg::HWWDT_OFF;
			end
		endcase
	end

	// State register; ce_in low models the stopped oscillator
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			r.state   <= hwwdt_pkg::HWWDT_OFF; // R2
			r.armed   <= 1'b0;
			r.sel     <= hwwdt_pkg::SEL_RESET; // R11
			r.mc      <= hwwdt_pkg::MC_RESET;
			r.presc   <= hwwdt_pkg::PRESC_RESET;
			r.base    <= hwwdt_pkg::BASE_RESET;
			r.pulse   <= hwwdt_pkg::PULSE_RESET;
			r.rdata   <= hwwdt_pkg::RESERVED_READ;
			r.rst_n_q <= 1'b1;
			r.hold    <= 1'b0;
		end else if (ce_in) begin
			r <= next_r; // R13 R18
		end
	end

	assign rdata_out   = r.rdata;
	assign rst_n_out   = r.rst_n_q;
	assign enabled_out = (r.state != hwwdt_pkg::HWWDT_OFF);

	// Assertions
	sequence s_unlock;
		wr_service && r.armed && sfr_in.wdata == hwwdt_pkg::UNLOCK_SECOND && ce_in;
	endsequence
	sequence s_ovf;
		r.state == hwwdt_pkg::HWWDT_RUN && base_ovf && !unlock_done && ce_in;
	endsequence

	AST_UNLOCK_ENABLES: assert property (@(posedge clk_in) disable iff (srst_in) // R1
		s_unlock |=> enabled_out) else $error("Unlock did not enable watchdog");
	AST_RESET_DISABLED: assert property (@(posedge clk_in) // R2
		srst_in |=> !enabled_out && r.base == 14'h0000) else $error("Not disabled after reset");
	AST_STAYS_ON: assert property (@(posedge clk_in) disable iff (srst_in) // R4
		(r.state == hwwdt_pkg::HWWDT_RUN) |=> enabled_out) else $error("Watchdog left running state");
	AST_SERVICE_CLEARS: assert property (@(posedge clk_in) disable iff (srst_in) // R6
		s_unlock and (r.state == hwwdt_pkg::HWWDT_RUN) |=> r.base == 14'h0000 && r.presc == 7'h00)
		else $error("Service did not clear counter");
	AST_OVF_PULSE: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in) // R5 R8
		s_ovf |=> !rst_n_out [*8]) else $error("Overflow pulse missing");
	AST_PULSE_LEN: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in) // R8
		$rose(!rst_n_out) |-> ##95 !rst_n_out ##1 rst_n_out) else $error("Reset pulse not 96 clocks");
	AST_BAD_SECOND: assert property (@(posedge clk_in) disable iff (srst_in) // R17
		wr_service && ce_in && r.armed && sfr_in.wdata != hwwdt_pkg::UNLOCK_SECOND
		&& sfr_in.wdata != hwwdt_pkg::UNLOCK_FIRST |=> !r.armed) else $error("Bad byte kept sequence");
	// Only the running state is checked: the end of a pulse clears the counters on purpose
	AST_HOLD_FREEZE: assert property (@(posedge clk_in) disable iff (srst_in) // R14
		r.state == hwwdt_pkg::HWWDT_RUN && r.hold && ce_in && !unlock_done
		|=> $stable(r.base) && $stable(r.mc)) else $error("Counted during hold");
	// Prescaler wrap must carry exactly one step into the base counter
	AST_PRESC_CARRY: assert property (@(posedge clk_in) disable iff (srst_in) // R9 R10
		r.state == hwwdt_pkg::HWWDT_RUN && presc_done && ce_in && !unlock_done && !base_ovf
		|=> r.presc == hwwdt_pkg::PRESC_RESET && r.base == $past(r.base) + 14'h0001)
		else $error("Prescaler carry wrong");
	// A disabled watchdog keeps its count at zero
	AST_OFF_NO_COUNT: assert property (@(posedge clk_in) disable iff (srst_in) // R2
		r.state == hwwdt_pkg::HWWDT_OFF && ce_in && !unlock_done
		|=> r.base == hwwdt_pkg::BASE_RESET) else $error("Counted while disabled");
	// Reading the time-out register returns the select field with zero upper bits
	AST_SEL_READ: assert property (@(posedge clk_in) disable iff (srst_in) // R11
		sfr_in.rd && ce_in && sfr_in.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR
		|=> rdata_out == {5'h00, $past(r.sel)}) else $error("Select readback wrong");
	AST_CE_FREEZE: assert property (@(posedge clk_in) disable iff (srst_in) // R13
		!ce_in |=> $stable(r.base) && $stable(r.state)) else $error("Counted with oscillator stopped");
	AST_MC_STEP: assert property (@(posedge clk_in) disable iff (srst_in) // R3
		r.state == hwwdt_pkg::HWWDT_RUN && mc_tick && ce_in && !unlock_done && !base_ovf
		|=> r.mc == 3'h0) else $error("Machine cycle divider wrong");
endmodule
`default_nettype wire

/* tb_hardware_watchdog_timer.sv */
// Self-checking testbench for the hardware watchdog timer top level.
// Assumes hwwdt_pkg and hwwdt_top are compiled first; the bench drives the SFR bus itself.
`timescale 1ns/10ps
`default_nettype none
module tb_hardware_watchdog_timer;
	logic                  clk_in;
	logic                  srst_in;
	logic                  ce_in;
	logic                  pd_wake_in;
	logic                  wake_int_n_in;
	hwwdt_pkg::hwwdt_sfr_t sfr;
	logic [7:0]            rdata_out;
	logic                  rst_n_out;
	logic                  enabled_out;
	int                    num_errors;
	int                    comparisons;
	int                    cyc = 0;

	hwwdt_top i_dut (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.ce_in         (ce_in),
		.sfr_in        (sfr),
		.pd_wake_in    (pd_wake_in),
		.wake_int_n_in (wake_int_n_in),
		.rdata_out     (rdata_out),
		.rst_n_out     (rst_n_out),
		.enabled_out   (enabled_out)
	);

	// 40 MHz clock and a free cycle count used to time the overflow
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) cyc <= cyc + 1;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Bus cycles change at the falling edge and are taken at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		sfr.wr = 1'b1;
		sfr.addr = a;
		sfr.wdata = d;
		@(negedge clk_in);
		sfr.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk_in);
		sfr.rd = 1'b1;
		sfr.addr = a;
		@(negedge clk_in);
		sfr.rd = 1'b0;
		chk(what, exp, rdata_out);
	endtask

	task automatic t_reset_state();
		chk("enabled after reset", 1'b0, enabled_out);
		chk("reset pin after reset", 1'b1, rst_n_out);
		rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00, "select after reset");
	endtask

	// A broken unlock pair must leave the block off; the service register reads nothing
	task automatic t_bad_sequence();
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h1e);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h55);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'he1);
		repeat (2) @(negedge clk_in);
		chk("enabled after broken pair", 1'b0, enabled_out);
		rd(hwwdt_pkg::SERVICE_ADDR, 8'h00, "service read");
	endtask

	task automatic t_timeout_field();
		wr(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h05);
		rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h05, "select readback");
		wr(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00);
		rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00, "select cleared");
	endtask

	// Unlock with a stray write to another address in between, then try to turn it off
	task automatic t_enable_lock();
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h1e);
		wr(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'he1);
		@(negedge clk_in);
		chk("enabled after pair", 1'b1, enabled_out);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h00);
		repeat (4) @(negedge clk_in);
		chk("enabled after stray write", 1'b1, enabled_out);
		// Idle keeps the clock running, so software services at a steady pace
		repeat (3) begin
			repeat (200) @(negedge clk_in);
			wr(hwwdt_pkg::SERVICE_ADDR, 8'h1e);
			wr(hwwdt_pkg::SERVICE_ADDR, 8'he1);
		end
		chk("enabled during idle servicing", 1'b1, enabled_out);
	endtask

	// Service, freeze the clock, hold the wake pin low, then time the overflow and pulse
	task automatic t_overflow();
		int t0;
		int dt;
		int lo;
		repeat (50) @(negedge clk_in);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h1e);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'he1);
		t0 = cyc;
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h1e);
		wr(hwwdt_pkg::SERVICE_ADDR, 8'h33);
		ce_in = 1'b0;
		repeat (200) @(negedge clk_in);
		ce_in = 1'b1;
		pd_wake_in = 1'b1;
		wake_int_n_in = 1'b0;
		repeat (100) @(negedge clk_in);
		wake_int_n_in = 1'b1;
		pd_wake_in = 1'b0;
		for (int i = 0; i < 100000 && rst_n_out === 1'b1; i++) @(negedge clk_in);
		dt = cyc - t0 - 300 - 16384 * hwwdt_pkg::MC_CLOCKS;
		chk("overflow delay in window", 1'b1, (dt >= -6 && dt <= 12));
		lo = 0;
		while (rst_n_out === 1'b0 && lo < 200) begin
			lo++;
			@(negedge clk_in);
		end
		chk("reset pulse length", hwwdt_pkg::RST_PULSE_PERIODS, lo);
		chk("enabled after pulse", 1'b0, enabled_out);
		rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00, "select after overflow");
	endtask

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog of the bench: the full time-out needs about 98.6k cycles
	initial begin
		repeat (110000) @(posedge clk_in);
		num_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		num_errors = 0;
		comparisons = 0;
		srst_in = 1'b1;
		ce_in = 1'b1;
		pd_wake_in = 1'b0;
		wake_int_n_in = 1'b1;
		sfr = '0;
		repeat (20) @(negedge clk_in);
		srst_in = 1'b0;
		t_reset_state();
		t_bad_sequence();
		t_timeout_field();
		t_enable_lock();
		t_overflow();
		wrap_up();
	end
endmodule
`default_nettype wire
